// [ued_consts.vh]
`ifndef UED_CONSTS_VH
`define UED_CONSTS_VH
`define UED_OFS_CTRL 8'h00
`define UED_OFS_EP_SEL 8'h04
`define UED_OFS_DMA_CFG 8'h08
`define UED_OFS_DMA_EN 8'h0C
`define UED_OFS_DMA_DIS 8'h10
`define UED_OFS_PKT_CNT 8'h14
`define UED_OFS_STATUS 8'h18
`define UED_OFS_CHAN_MAP 8'h1C
`define UED_OFS_EP_CFG 8'h20
`define UED_OFS_NAK_LIMIT 8'h24
`define UED_DIR_BIT 8
`define UED_CFG_MODE1 0
`define UED_CFG_AUTO_SEND 1
`define UED_CFG_AUTO_ACK 2
`define UED_CFG_AUTO_INREQ 3
`define UED_RST_NAK_LIMIT 8'h10
`define UED_FLG_H_RX_NAK_TO 4
`define UED_FLG_H_TX_NAK_TO 8
`define UED_FLG_H_CTL_NAK_TO 14
`define UED_ERR_MASK 32'h331DCF3F
`endif

// [ued_cnt_mem.v]
`timescale 1ns/1ns
module ued_cnt_mem
(
  // Clock
  input wire clk,
  // Write port
  input wire we,
  input wire [2:0] waddr,
  input wire [15:0] wdata,
  // Registered read ports
  input wire [2:0] raddr_a,
  output reg [15:0] rdata_a,
  input wire [2:0] raddr_b,
  output reg [15:0] rdata_b
);
  reg [15:0] mem [0:7];

  always @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end
endmodule // ued_cnt_mem

// [ued_flag_bank.v]
`timescale 1ns/1ns
module ued_flag_bank
(
  // Clock and reset
  input wire clk,
  input wire rst,
  // Set and clear strobes
  input wire [31:0] set,
  input wire [31:0] clr,
  // Sticky flags
  output reg [31:0] flags
);
  always @(posedge clk)
  begin
    if (rst)
    begin
      flags <= 32'h00000000;
    end
    else
    begin
      flags <= (flags & ~clr) | set;
    end
  end
endmodule // ued_flag_bank

// [ued_top.v]
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
`include "ued_consts.vh"
module ued_top
(
  // Clock and reset
  input wire clk,
  input wire rst,
  // Avalon-MM slave
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  // Controller core events
  input wire [2:0] core_ep,
  input wire core_dir_tx,
  input wire core_evt,
  input wire [4:0] core_code,
  input wire core_ep_reset,
  input wire core_pkt_done,
  input wire core_dma_done,
  input wire core_tx_full_pkt,
  input wire core_rx_drained,
  input wire core_nak,
  input wire core_ok,
  input wire core_sof,
  // FIFO levels per endpoint
  input wire [7:0] ep_tx_space,
  input wire [7:0] ep_rx_avail,
  // DMA requests
  output reg [2:0] dma_rx_req,
  output reg [2:0] dma_tx_req,
  // Automatic actions
  output reg tx_pkt_set,
  output reg rx_pkt_ack,
  output reg in_request,
  output reg [2:0] auto_ep,
  // Endpoint interrupt pulses
  output reg [7:0] ep_irq,
  // Mode
  output reg host_mode
);
  function [7:0] dec8;
    input [2:0] n;
    begin
      dec8 = 8'h01 << n;
    end
  endfunction

  reg [2:0] sel_ep;
  reg [7:0] tx_en;
  reg [7:0] rx_en;
  reg [7:0] tx_m1;
  reg [7:0] rx_m1;
  reg [7:0] tx_auto_send;
  reg [7:0] rx_auto_ack;
  reg [7:0] rx_auto_in_request;
  reg [7:0] ep_bulk;
  reg [7:0] nak_limit;
  reg [17:0] chan_map;
  reg [15:0] req_cnt [0:7];
  reg [7:0] nak_act;
  reg [7:0] nak_dir_tx;
  reg [7:0] nak_frm [0:7];
  reg drain_q;
  reg [2:0] drain_ep;
  wire [7:0] nak_to;
  wire [31:0] flags [0:7];
  wire [15:0] cnt_bus;
  wire [15:0] cnt_core;
  wire wr_go = write && !waitrequest;
  wire pkt_wr = wr_go && (address == `UED_OFS_PKT_CNT);
  wire wdir = writedata[`UED_DIR_BIT];
  wire [7:0] sel_dec = dec8(sel_ep);
  wire [7:0] core_dec = dec8(core_ep);
  wire [31:0] code_dec = 32'h00000001 << core_code;
  wire en_wr = wr_go && (address == `UED_OFS_DMA_EN);
  wire dis_wr = wr_go && (address == `UED_OFS_DMA_DIS);

  ued_cnt_mem u_cnt
  (
    .clk(clk),
    .we(pkt_wr),
    .waddr(sel_ep),
    .wdata(writedata[15:0]),
    .raddr_a(sel_ep),
    .rdata_a(cnt_bus),
    .raddr_b(core_rx_drained ? core_ep : drain_ep),
    .rdata_b(cnt_core)
  );

  // Auto-request allowed while fewer requests than the packet count went out;
  // the count is fetched for the drained endpoint so it is ready with drain_ep
  wire in_req_ok = host_mode && rx_en[drain_ep] && rx_auto_in_request[drain_ep] &&
    (req_cnt[drain_ep] < cnt_core);

  // Per-endpoint flags, NAK timers and request counters
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_ep
      wire hit = core_dec[i];
      wire bulk_like = (i == 0) || ep_bulk[i];
      wire [31:0] nak_bit = (i == 0) ? (32'h00000001 << `UED_FLG_H_CTL_NAK_TO) :
        nak_dir_tx[i] ? (32'h00000001 << `UED_FLG_H_TX_NAK_TO) : (32'h00000001 << `UED_FLG_H_RX_NAK_TO);
      wire [31:0] set = ((core_evt && hit) ? code_dec : 32'h00000000) |
        (nak_to[i] ? nak_bit : 32'h00000000);
      wire [31:0] clr = ((core_ep_reset && hit) ? 32'hFFFFFFFF : 32'h00000000) |
        ((wr_go && address == `UED_OFS_STATUS && sel_dec[i]) ? writedata : 32'h00000000);

      // More than the limit of frames with NAKs ends the wait
      assign nak_to[i] = bulk_like && nak_act[i] && core_sof && (nak_frm[i] == nak_limit) &&
        !(core_ok && hit);

      ued_flag_bank u_flags
      (
        .clk(clk),
        .rst(rst),
        .set(set),
        .clr(clr),
        .flags(flags[i])
      );

      always @(posedge clk)
      begin
        if (rst)
        begin
          nak_act[i] <= 1'b0;
          nak_dir_tx[i] <= 1'b0;
          nak_frm[i] <= 8'h00;
          req_cnt[i] <= 16'h0000;
        end
        else
        begin
          if ((core_ok || core_ep_reset) && hit)
          begin
            nak_act[i] <= 1'b0;
            nak_frm[i] <= 8'h00;
          end
          else
          begin
            if (core_nak && hit)
            begin
              nak_act[i] <= 1'b1;
              nak_dir_tx[i] <= core_dir_tx;
            end
            if (core_sof && nak_act[i] && nak_frm[i] != 8'hFF)
            begin
              nak_frm[i] <= nak_frm[i] + 8'h01;
            end
          end
          if ((pkt_wr || (en_wr && !wdir)) && sel_dec[i])
          begin
            req_cnt[i] <= 16'h0000;
          end
          else if (drain_q && drain_ep == i && in_req_ok)
          begin
            req_cnt[i] <= req_cnt[i] + 16'h0001;
          end
        end
      end
    end
  endgenerate

  // Register writes
  always @(posedge clk)
  begin
    if (rst)
    begin
      host_mode <= 1'b0;
      sel_ep <= 3'h0;
      tx_en <= 8'h00;
      rx_en <= 8'h00;
      tx_m1 <= 8'h00;
      rx_m1 <= 8'h00;
      tx_auto_send <= 8'h00;
      rx_auto_ack <= 8'h00;
      rx_auto_in_request <= 8'h00;
      ep_bulk <= 8'h00;
      nak_limit <= `UED_RST_NAK_LIMIT;
      chan_map <= 18'h00000;
    end
    else if (wr_go)
    begin
      case (address)
        `UED_OFS_CTRL: host_mode <= writedata[0];
        `UED_OFS_EP_SEL: sel_ep <= writedata[2:0];
        `UED_OFS_DMA_CFG:
        begin
          // Only DMA fields of the chosen direction change
          if (wdir)
          begin
            tx_m1[sel_ep] <= writedata[`UED_CFG_MODE1];
            tx_auto_send[sel_ep] <= writedata[`UED_CFG_AUTO_SEND];
          end
          else
          begin
            rx_m1[sel_ep] <= writedata[`UED_CFG_MODE1];
            rx_auto_ack[sel_ep] <= writedata[`UED_CFG_AUTO_ACK];
            rx_auto_in_request[sel_ep] <= writedata[`UED_CFG_AUTO_INREQ];
          end
        end
        `UED_OFS_DMA_EN:
        begin
          if (wdir)
          begin
            tx_en[sel_ep] <= 1'b1;
          end
          else
          begin
            rx_en[sel_ep] <= 1'b1;
          end
        end
        `UED_OFS_DMA_DIS:
        begin
          if (wdir)
          begin
            tx_en[sel_ep] <= 1'b0;
          end
          else
          begin
            rx_en[sel_ep] <= 1'b0;
          end
        end
        `UED_OFS_CHAN_MAP: chan_map <= writedata[17:0];
        `UED_OFS_EP_CFG: ep_bulk[sel_ep] <= writedata[0];
        `UED_OFS_NAK_LIMIT: nak_limit <= writedata[7:0];
        default: ;
      endcase
    end
  end

  // Bus answer: one wait state, data latched with the release
  always @(posedge clk)
  begin
    if (rst)
    begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end
    else
    begin
      waitrequest <= !((read || write) && waitrequest);
      if (read && waitrequest)
      begin
        case (address)
          `UED_OFS_CTRL: readdata <= {31'h00000000, host_mode};
          `UED_OFS_EP_SEL: readdata <= {29'h00000000, sel_ep};
          `UED_OFS_DMA_CFG: readdata <= {25'h0000000, rx_en[sel_ep], tx_en[sel_ep], rx_m1[sel_ep],
            rx_auto_in_request[sel_ep], rx_auto_ack[sel_ep], tx_auto_send[sel_ep], tx_m1[sel_ep]};
          `UED_OFS_PKT_CNT: readdata <= {16'h0000, cnt_bus};
          `UED_OFS_STATUS: readdata <= flags[sel_ep];
          `UED_OFS_CHAN_MAP: readdata <= {14'h0000, chan_map};
          `UED_OFS_EP_CFG: readdata <= {31'h00000000, ep_bulk[sel_ep]};
          `UED_OFS_NAK_LIMIT: readdata <= {24'h000000, nak_limit};
          default: readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // DMA request channels; a channel mapped to endpoint zero stays idle
  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1)
    begin : g_ch
      wire [2:0] rx_ep = chan_map[3 * c + 2:3 * c];
      wire [2:0] tx_ep = chan_map[3 * c + 11:3 * c + 9];
      always @(posedge clk)
      begin
        if (rst)
        begin
          dma_rx_req[c] <= 1'b0;
          dma_tx_req[c] <= 1'b0;
        end
        else
        begin
          // Receive channels drain FIFO to memory, transmit channels fill it
          dma_rx_req[c] <= (rx_ep != 3'h0) && rx_en[rx_ep] && ep_rx_avail[rx_ep];
          dma_tx_req[c] <= (tx_ep != 3'h0) && tx_en[tx_ep] && ep_tx_space[tx_ep];
        end
      end
    end
  endgenerate

  // Automatic packet handling and interrupt filtering
  reg [7:0] next_irq;
  always @*
  begin
    next_irq = 8'h00;
    if (core_evt && ((code_dec & `UED_ERR_MASK) != 32'h00000000))
    begin
      next_irq = core_dec;
    end
    if (core_pkt_done && !(core_dir_tx ? tx_en[core_ep] : rx_en[core_ep]))
    begin
      next_irq = next_irq | core_dec;
    end
    if (core_dma_done && (core_dir_tx ? (tx_en[core_ep] && tx_m1[core_ep]) :
      (rx_en[core_ep] && rx_m1[core_ep])))
    begin
      next_irq = next_irq | core_dec;
    end
    next_irq = next_irq | nak_to;
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      tx_pkt_set <= 1'b0;
      rx_pkt_ack <= 1'b0;
      in_request <= 1'b0;
      auto_ep <= 3'h0;
      ep_irq <= 8'h00;
      drain_q <= 1'b0;
      drain_ep <= 3'h0;
    end
    else
    begin
      ep_irq <= next_irq;
      tx_pkt_set <= core_tx_full_pkt && tx_en[core_ep] && tx_auto_send[core_ep];
      rx_pkt_ack <= core_rx_drained && rx_en[core_ep] && rx_auto_ack[core_ep];
      drain_q <= core_rx_drained;
      if (core_rx_drained)
      begin
        drain_ep <= core_ep;
      end
      in_request <= drain_q && in_req_ok;
      if (core_tx_full_pkt || core_rx_drained)
      begin
        auto_ep <= core_ep;
      end
      else if (drain_q)
      begin
        auto_ep <= drain_ep;
      end
    end
  end
endmodule // ued_top

// [ued_top_sva.sv]
`timescale 1ns/1ns
`include "ued_consts.vh"
module ued_top_sva
(
  // Clock and reset
  input wire clk,
  input wire rst,
  // Bus
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] readdata,
  input wire waitrequest,
  // Core events
  input wire [2:0] core_ep,
  input wire core_evt,
  input wire core_pkt_done,
  input wire core_dma_done,
  input wire core_tx_full_pkt,
  input wire core_rx_drained,
  input wire core_sof,
  input wire [7:0] ep_tx_space,
  input wire [7:0] ep_rx_avail,
  // Outputs
  input wire [2:0] dma_rx_req,
  input wire [2:0] dma_tx_req,
  input wire tx_pkt_set,
  input wire rx_pkt_ack,
  input wire in_request,
  input wire [2:0] auto_ep,
  input wire [7:0] ep_irq,
  input wire host_mode
);
  wire any_evt = core_evt | core_pkt_done | core_dma_done | core_sof;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ans;
    read && !waitrequest;
  endsequence
  sequence s_blank_addr;
    address > `UED_OFS_NAK_LIMIT || address == `UED_OFS_DMA_EN || address == `UED_OFS_DMA_DIS;
  endsequence
  AST_ACK_CAUSE: assert property (rx_pkt_ack |-> $past(core_rx_drained))
    else $error("ack without drained fifo");
  AST_SEND_CAUSE: assert property (tx_pkt_set |-> $past(core_tx_full_pkt))
    else $error("send without full packet");
  AST_INREQ_CAUSE: assert property (in_request |-> $past(core_rx_drained, 2) && $past(host_mode))
    else $error("in request without cause");
  AST_AUTO_EP: assert property (rx_pkt_ack || tx_pkt_set |-> auto_ep == $past(core_ep))
    else $error("automatic action on wrong endpoint");
  AST_IRQ_CAUSE: assert property (ep_irq != 8'h00 |-> $past(any_evt) || $past(any_evt, 2))
    else $error("interrupt without event");
  AST_BLANK_READ: assert property (s_ans ##0 s_blank_addr |-> readdata == 32'h0)
    else $error("blank address read nonzero");
  AST_MODE_HOLD: assert property (host_mode != $past(host_mode) |->
    $past(rst) || $past(write && !waitrequest && address == `UED_OFS_CTRL))
    else $error("mode changed without write");
  AST_RX_REQ: assert property (dma_rx_req != 3'h0 |-> $past(ep_rx_avail[7:1]) != 7'h00)
    else $error("rx dma request without data");
  AST_TX_REQ: assert property (dma_tx_req != 3'h0 |-> $past(ep_tx_space[7:1]) != 7'h00)
    else $error("tx dma request without space");
endmodule // ued_top_sva
bind ued_top ued_top_sva i_sva (.clk, .rst, .address, .read, .write, .readdata, .waitrequest,
  .core_ep, .core_evt, .core_pkt_done, .core_dma_done, .core_tx_full_pkt, .core_rx_drained,
  .core_sof, .ep_tx_space, .ep_rx_avail, .dma_rx_req, .dma_tx_req, .tx_pkt_set, .rx_pkt_ack,
  .in_request, .auto_ep, .ep_irq, .host_mode);

// [ued_peer_model.sv]
`timescale 1ns/1ns
module ued_peer_model
(
  // Clock
  input wire clk,
  // Core event pulses
  output reg [2:0] core_ep,
  output reg core_dir_tx,
  output reg core_evt,
  output reg [4:0] core_code,
  output reg core_ep_reset,
  output reg core_pkt_done,
  output reg core_dma_done,
  output reg core_tx_full_pkt,
  output reg core_rx_drained,
  output reg core_nak,
  output reg core_ok,
  output reg core_sof,
  // FIFO levels
  output reg [7:0] ep_tx_space,
  output reg [7:0] ep_rx_avail
);
  reg [8:0] hot = 9'h000;
  initial
  begin
    {core_ep, core_dir_tx, core_code, ep_tx_space, ep_rx_avail} = 25'h0000000;
  end
  // Runs at time zero too, so the pulses are low before the first fire
  always_comb
  begin
    {core_sof, core_ok, core_nak, core_rx_drained, core_tx_full_pkt, core_dma_done, core_pkt_done,
      core_ep_reset, core_evt} = hot;
  end
  // One pulse of kind k, standing exactly one clock
  task fire(input [3:0] k, input [2:0] ep, input dir, input [4:0] code);
    @(posedge clk);
    core_ep <= ep;
    core_dir_tx <= dir;
    core_code <= code;
    hot <= 9'h001 << k;
    @(posedge clk);
    hot <= 9'h000;
  endtask
  task level(input [7:0] tx, input [7:0] rx);
    @(posedge clk);
    ep_tx_space <= tx;
    ep_rx_avail <= rx;
  endtask
endmodule // ued_peer_model

// [tb_top.sv]
`timescale 1ns/1ns
`include "ued_consts.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module tb_top;
  localparam K_EVT = 0, K_RST = 1, K_PKT = 2, K_DMA = 3, K_FULL = 4, K_DRN = 5, K_NAK = 6, K_SOF = 8;
  reg clk = 0;
  reg rst = 1;
  reg [7:0] address = 8'h00;
  reg read = 0, write = 0;
  reg [31:0] writedata = 32'h0, d;
  wire [31:0] readdata;
  wire waitrequest, core_dir_tx, core_evt, core_ep_reset, core_pkt_done, core_dma_done;
  wire core_tx_full_pkt, core_rx_drained, core_nak, core_ok, core_sof;
  wire tx_pkt_set, rx_pkt_ack, in_request, host_mode;
  wire [2:0] core_ep, dma_rx_req, dma_tx_req, auto_ep;
  wire [4:0] core_code;
  wire [7:0] ep_tx_space, ep_rx_avail, ep_irq;
  int failures = 0, comparisons = 0, acks = 0, reqs = 0, sets = 0, irqs = 0, i, j;
  ued_top i_dut (.clk, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .core_ep, .core_dir_tx, .core_evt, .core_code, .core_ep_reset, .core_pkt_done, .core_dma_done,
    .core_tx_full_pkt, .core_rx_drained, .core_nak, .core_ok, .core_sof, .ep_tx_space, .ep_rx_avail,
    .dma_rx_req, .dma_tx_req, .tx_pkt_set, .rx_pkt_ack, .in_request, .auto_ep, .ep_irq, .host_mode);
  ued_peer_model i_peer (.clk, .core_ep, .core_dir_tx, .core_evt, .core_code, .core_ep_reset,
    .core_pkt_done, .core_dma_done, .core_tx_full_pkt, .core_rx_drained, .core_nak, .core_ok,
    .core_sof, .ep_tx_space, .ep_rx_avail);
  initial
  begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    acks <= acks + rx_pkt_ack;
    reqs <= reqs + in_request;
    sets <= sets + tx_pkt_set;
    irqs <= irqs + (ep_irq != 8'h00);
  end
  task conclude;
    $display("counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task bus(input w, input [7:0] a, input [31:0] wd);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= wd;
    read <= !w;
    write <= w;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 20);
    d = readdata;
    read <= 0;
    write <= 0;
    if (waitrequest !== 1'b0)
    begin
      failures++;
      conclude();
    end
  endtask
  task wr(input [7:0] a, input [31:0] wd);
    bus(1, a, wd);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    bus(0, a, 32'h0);
    `CHK(d, e)
  endtask
  task gap;
    repeat (3) @(posedge clk);
  endtask
  initial
  begin
    repeat (50000) @(posedge clk);
    failures++;
    conclude();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    rd(`UED_OFS_DMA_CFG, 32'h0);
    rd(`UED_OFS_NAK_LIMIT, 32'h10);
    rd(8'h40, 32'h0);
    $display("test reset done");
    wr(`UED_OFS_EP_SEL, 32'h1);
    wr(`UED_OFS_EP_CFG, 32'h1);
    wr(`UED_OFS_DMA_CFG, 32'h103);
    wr(`UED_OFS_DMA_CFG, 32'h00F);
    rd(`UED_OFS_EP_CFG, 32'h1);
    rd(`UED_OFS_DMA_CFG, 32'h1F);
    wr(`UED_OFS_DMA_EN, 32'h100);
    rd(`UED_OFS_DMA_CFG, 32'h3F);
    rd(`UED_OFS_DMA_EN, 32'h0);
    i_peer.fire(K_FULL, 1, 1, 0);
    gap();
    `CHK(sets, 1)
    wr(`UED_OFS_DMA_DIS, 32'h1FF);
    rd(`UED_OFS_DMA_CFG, 32'h1F);
    wr(`UED_OFS_DMA_EN, 32'h0);
    rd(`UED_OFS_DMA_CFG, 32'h5F);
    $display("test config done");
    wr(`UED_OFS_CTRL, 32'h1);
    wr(`UED_OFS_PKT_CNT, 32'h2);
    repeat (3)
    begin
      i_peer.fire(K_DRN, 1, 0, 0);
      gap();
    end
    `CHK(acks, 3)
    `CHK(reqs, 2)
    wr(`UED_OFS_CHAN_MAP, 32'h1);
    i_peer.level(8'h02, 8'h02);
    gap();
    `CHK(dma_rx_req, 3'b001)
    `CHK(dma_tx_req, 3'b000)
    wr(`UED_OFS_CHAN_MAP, 32'h0);
    gap();
    `CHK(dma_rx_req, 3'b000)
    i_peer.level(8'h00, 8'h00);
    $display("test auto and dma done");
    j = irqs;
    i_peer.fire(K_PKT, 3, 0, 0);
    gap();
    `CHK(irqs, j + 1)
    i_peer.fire(K_PKT, 1, 0, 0);
    i_peer.fire(K_DMA, 1, 0, 0);
    gap();
    `CHK(irqs, j + 2)
    wr(`UED_OFS_EP_SEL, 32'h3);
    wr(`UED_OFS_DMA_CFG, 32'h0);
    wr(`UED_OFS_DMA_EN, 32'h0);
    i_peer.fire(K_PKT, 3, 0, 0);
    i_peer.fire(K_DMA, 3, 0, 0);
    gap();
    `CHK(irqs, j + 2)
    $display("test interrupts done");
    wr(`UED_OFS_EP_SEL, 32'h2);
    for (i = 0; i < 32; i++)
    begin
      i_peer.fire(K_EVT, 2, 0, i[4:0]);
      gap();
      rd(`UED_OFS_STATUS, 32'h1 << i);
      wr(`UED_OFS_STATUS, 32'h1 << i);
      rd(`UED_OFS_STATUS, 32'h0);
    end
    i_peer.fire(K_EVT, 2, 0, 7);
    i_peer.fire(K_RST, 2, 0, 0);
    gap();
    rd(`UED_OFS_STATUS, 32'h0);
    wr(`UED_OFS_EP_CFG, 32'h1);
    wr(`UED_OFS_NAK_LIMIT, 32'h2);
    for (i = 0; i < 3; i++)
    begin
      if (i == 2)
        rd(`UED_OFS_STATUS, 32'h0);
      i_peer.fire(K_NAK, 2, 0, 0);
      i_peer.fire(K_SOF, 2, 0, 0);
      gap();
    end
    rd(`UED_OFS_STATUS, 32'h1 << `UED_FLG_H_RX_NAK_TO);
    $display("test flags done");
    conclude();
  end
endmodule // tb_top
